/* verilog/tdq_pkg.sv */
// constants for the transmit descriptor sequencer
// assumes: 32-bit descriptors of link, cmdsts, buffer pointer words
`default_nettype none
package tdq_pkg;
   // register byte offsets
   localparam logic [3:0] CMD_OFF = 4'h0;
   localparam logic [3:0] CFG_OFF = 4'h4;
   localparam logic [3:0] PTR_OFF = 4'h8;
   localparam logic [3:0] STAT_OFF = 4'hC;
   // command / status bits
   localparam int ENABLE_BIT = 0;
   localparam int IDLE_BIT = 0;
   localparam int DONE_BIT = 1;
   localparam int STATE_LSB = 4;
   // config fields: fill threshold [11:0], descriptor words [19:16]
   localparam int THR_LSB = 0;
   localparam int DWORDS_LSB = 16;
   localparam logic [31:0] CFG_RESET = 32'h0003_0040;
   // descriptor layout
   localparam logic [31:0] LINK_OFF = 32'h0000_0000;
   localparam logic [31:0] CMDSTS_OFF = 32'h0000_0004;
   localparam logic [31:0] BUFPTR_OFF = 32'h0000_0008;
   localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
   localparam int OWN_BIT = 31;
   localparam int MORE_BIT = 30;
   localparam int SIZE_W = 12;
   localparam logic [3:0] UPPER_HALF_BE = 4'hC;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   typedef enum logic [1:0] {
      KIND_DESC, KIND_REFRESH, KIND_FRAG, KIND_STATUS
   } tdq_kind_t;
   typedef enum logic [2:0] {
      xmit_state_quiet, descriptor_fetch_state, link_refresh_state, queue_wait_state,
      fragment_fetch_state, status_writeback_state, list_advance_state
   } tdq_state_t;
endpackage : tdq_pkg
`default_nettype wire

/* verilog/tdq_sequencer.sv */
// transmit descriptor list walker: fetches descriptors, issues fragment
// bursts into the transmit queue, writes status back for descriptors with the more bit set, follows links.
// assumes a bus-master engine that takes one request pulse, returns read
// words on rd_valid_i before pulsing xfer_done_i, and aligns bytes itself.
`default_nettype none
module tdq_sequencer #(
   parameter int SPACE_W = 12
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // axi4-lite slave
   input wire logic [3:0] s_awaddr_i,
   input wire logic s_awvalid_i,
   output logic s_awready_o,
   input wire logic [31:0] s_wdata_i,
   input wire logic [3:0] s_wstrb_i,
   input wire logic s_wvalid_i,
   output logic s_wready_o,
   output logic [1:0] s_bresp_o,
   output logic s_bvalid_o,
   input wire logic s_bready_i,
   input wire logic [3:0] s_araddr_i,
   input wire logic s_arvalid_i,
   output logic s_arready_o,
   output logic [31:0] s_rdata_o,
   output logic [1:0] s_rresp_o,
   output logic s_rvalid_o,
   input wire logic s_rready_i,
   // bus-master request engine
   output logic xfer_req_o,
   output logic [1:0] xfer_kind_o,
   output logic [31:0] xfer_addr_o,
   output logic [SPACE_W-1:0] xfer_len_o,
   output logic [31:0] xfer_wdata_o,
   output logic [3:0] xfer_be_o,
   input wire logic rd_valid_i,
   input wire logic [31:0] rd_data_i,
   input wire logic xfer_done_i,
   // transmit queue
   input wire logic [SPACE_W-1:0] queue_free_space_i,
   output logic handle_valid_o,
   output logic [31:0] handle_data_o
);
   tdq_pkg::tdq_state_t state;
   logic [31:0] xmit_descriptor_pointer;
   logic current_desc_done_flag;
   logic xmit_enable_cmd;
   logic xmit_went_idle_status;
   logic [31:0] xmit_config_register;
   logic [31:0] link, cmdsts, fragment_pointer;
   localparam int SIZE_W_L = tdq_pkg::SIZE_W;
   logic [SIZE_W_L-1:0] remaining_byte_count;
   logic [1:0] word_idx;
   // awaiting halves of a write
   logic aw_held, w_held;
   logic [3:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic sw_wr;
   logic [31:0] sw_val, cur_val;

   logic queue_space_event, bus_transfer_complete, desc_own, desc_more, link_null;
   logic [SPACE_W-1:0] thr, count_ext, burst_len;
   logic [31:0] desc_len;

   assign bus_transfer_complete = xfer_done_i;
   assign thr = xmit_config_register[tdq_pkg::THR_LSB +: SPACE_W];
   assign queue_space_event = queue_free_space_i > thr;
   assign count_ext = SPACE_W'(remaining_byte_count);
   assign burst_len = (queue_free_space_i < count_ext) ? queue_free_space_i : count_ext;
   assign desc_len = {26'h000_0000, xmit_config_register[tdq_pkg::DWORDS_LSB +: 4], 2'h0};
   assign desc_own = cmdsts[tdq_pkg::OWN_BIT];
   assign desc_more = cmdsts[tdq_pkg::MORE_BIT];
   assign link_null = (link == 32'h0000_0000);
   assign sw_wr = aw_held && w_held && !s_bvalid_o;

   // register write: byte strobes merged into current value
   always_comb begin
      unique case (aw_addr)
         tdq_pkg::CMD_OFF: cur_val = {31'h0000_0000, xmit_enable_cmd};
         tdq_pkg::CFG_OFF: cur_val = xmit_config_register;
         tdq_pkg::PTR_OFF: cur_val = xmit_descriptor_pointer;
         default: cur_val = 32'h0000_0000;
      endcase
      for (int b = 0; b < 4; b++) begin
         sw_val[8*b +: 8] = w_strb[b] ? w_data[8*b +: 8] : cur_val[8*b +: 8];
      end
   end

   // axi write channel: address and data taken in either order
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 4'h0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_bvalid_o <= 1'b0;
         s_bresp_o <= tdq_pkg::RESP_OKAY;
      end else begin
         if (s_awvalid_i && s_awready_o) begin
            aw_held <= 1'b1;
            aw_addr <= s_awaddr_i;
         end
         if (s_wvalid_i && s_wready_o) begin
            w_held <= 1'b1;
            w_data <= s_wdata_i;
            w_strb <= s_wstrb_i;
         end
         if (sw_wr) begin
            s_bvalid_o <= 1'b1;
            s_bresp_o <= (aw_addr[1:0] == 2'h0) ? tdq_pkg::RESP_OKAY : tdq_pkg::RESP_DECERR;
            aw_held <= 1'b0;
            w_held <= 1'b0;
         end else if (s_bvalid_o && s_bready_i) begin
            s_bvalid_o <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_awready_o <= 1'b0;
         s_wready_o <= 1'b0;
      end else begin
         s_awready_o <= !aw_held && !(s_awvalid_i && s_awready_o) && !s_bvalid_o;
         s_wready_o <= !w_held && !(s_wvalid_i && s_wready_o) && !s_bvalid_o;
      end
   end

   // axi read channel
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_arready_o <= 1'b0;
         s_rvalid_o <= 1'b0;
         s_rdata_o <= 32'h0000_0000;
         s_rresp_o <= tdq_pkg::RESP_OKAY;
      end else begin
         s_arready_o <= !s_rvalid_o && !(s_arvalid_i && s_arready_o);
         if (s_arvalid_i && s_arready_o) begin
            s_rvalid_o <= 1'b1;
            s_rresp_o <= tdq_pkg::RESP_OKAY;
            unique case (s_araddr_i)
               tdq_pkg::CMD_OFF: s_rdata_o <= {31'h0000_0000, xmit_enable_cmd};
               tdq_pkg::CFG_OFF: s_rdata_o <= xmit_config_register;
               tdq_pkg::PTR_OFF: s_rdata_o <= xmit_descriptor_pointer;
               tdq_pkg::STAT_OFF: begin
                  s_rdata_o <= 32'h0000_0000;
                  s_rdata_o[tdq_pkg::IDLE_BIT] <= xmit_went_idle_status;
                  s_rdata_o[tdq_pkg::DONE_BIT] <= current_desc_done_flag;
                  s_rdata_o[tdq_pkg::STATE_LSB +: 3] <= state;
               end
               default: begin
                  s_rdata_o <= 32'h0000_0000;
                  s_rresp_o <= tdq_pkg::RESP_DECERR;
               end
            endcase
         end else if (s_rvalid_o && s_rready_i) begin
            s_rvalid_o <= 1'b0;
         end
      end
   end

   // config register
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         xmit_config_register <= tdq_pkg::CFG_RESET;
      end else if (sw_wr && aw_addr == tdq_pkg::CFG_OFF) begin
         xmit_config_register <= sw_val;
      end
   end

   // enable: software set wins over the hardware clear at list end
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         xmit_enable_cmd <= 1'b0;
      end else if (sw_wr && aw_addr == tdq_pkg::CMD_OFF) begin
         xmit_enable_cmd <= sw_val[tdq_pkg::ENABLE_BIT];
      end else if (state == tdq_pkg::list_advance_state && link_null) begin
         xmit_enable_cmd <= 1'b0;
      end
   end

   // idle status, write one to clear; a new event wins over the clear
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         xmit_went_idle_status <= 1'b0;
      end else if ((state == tdq_pkg::descriptor_fetch_state && bus_transfer_complete
            && !desc_own) || (state == tdq_pkg::list_advance_state && link_null)) begin
         xmit_went_idle_status <= 1'b1;
      end else if (sw_wr && aw_addr == tdq_pkg::STAT_OFF && w_strb[0]
            && w_data[tdq_pkg::IDLE_BIT]) begin
         xmit_went_idle_status <= 1'b0;
      end
   end

   // pointer and done flag: set wins over a same-cycle pointer write
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         xmit_descriptor_pointer <= 32'h0000_0000;
         current_desc_done_flag <= 1'b0;
      end else begin
         if (state == tdq_pkg::list_advance_state && !link_null) begin
            xmit_descriptor_pointer <= link;
         end else if (sw_wr && aw_addr == tdq_pkg::PTR_OFF) begin
            xmit_descriptor_pointer <= sw_val;
         end
         if ((state == tdq_pkg::list_advance_state && link_null) ||
               (state == tdq_pkg::status_writeback_state && bus_transfer_complete)) begin
            current_desc_done_flag <= 1'b1;
         end else if ((state == tdq_pkg::list_advance_state) ||
               (sw_wr && aw_addr == tdq_pkg::PTR_OFF)) begin
            current_desc_done_flag <= 1'b0;
         end
      end
   end

   // descriptor cache: words arrive in order link, cmdsts, buffer pointer
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         word_idx <= 2'h0;
         link <= 32'h0000_0000;
         cmdsts <= 32'h0000_0000;
      end else begin
         if (xfer_req_o) begin
            word_idx <= 2'h0;
         end else if (rd_valid_i) begin
            word_idx <= word_idx + 2'h1;
         end
         if (rd_valid_i && (state == tdq_pkg::link_refresh_state ||
               (state == tdq_pkg::descriptor_fetch_state && word_idx == 2'h0))) begin
            link <= rd_data_i;
         end
         if (rd_valid_i && state == tdq_pkg::descriptor_fetch_state && word_idx == 2'h1) begin
            cmdsts <= rd_data_i;
         end
      end
   end

   // fragment pointer and byte count, any byte alignment passed through
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         fragment_pointer <= 32'h0000_0000;
         remaining_byte_count <= '0;
      end else if (state == tdq_pkg::descriptor_fetch_state && rd_valid_i) begin
         if (word_idx == 2'h1) begin
            remaining_byte_count <= rd_data_i[SIZE_W_L-1:0];
         end
         if (word_idx == 2'h2) begin
            fragment_pointer <= rd_data_i;
         end
      end else if (state == tdq_pkg::queue_wait_state && remaining_byte_count != '0
            && queue_space_event) begin
         remaining_byte_count <= remaining_byte_count - SIZE_W_L'(burst_len);
         fragment_pointer <= fragment_pointer + 32'(burst_len);
      end
   end

   // sequencer and request outputs
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= tdq_pkg::xmit_state_quiet;
         xfer_req_o <= 1'b0;
         xfer_kind_o <= tdq_pkg::KIND_DESC;
         xfer_addr_o <= 32'h0000_0000;
         xfer_len_o <= '0;
         xfer_wdata_o <= 32'h0000_0000;
         xfer_be_o <= 4'h0;
         handle_valid_o <= 1'b0;
         handle_data_o <= 32'h0000_0000;
      end else begin
         xfer_req_o <= 1'b0;
         handle_valid_o <= 1'b0;
         unique case (state)
            tdq_pkg::xmit_state_quiet: if (xmit_enable_cmd) begin
               xfer_req_o <= 1'b1;
               xfer_be_o <= 4'hF;
               if (!current_desc_done_flag) begin
                  state <= tdq_pkg::descriptor_fetch_state;
                  xfer_kind_o <= tdq_pkg::KIND_DESC;
                  xfer_addr_o <= xmit_descriptor_pointer;
                  xfer_len_o <= SPACE_W'(desc_len);
               end else begin
                  state <= tdq_pkg::link_refresh_state;
                  xfer_kind_o <= tdq_pkg::KIND_REFRESH;
                  xfer_addr_o <= xmit_descriptor_pointer + tdq_pkg::LINK_OFF;
                  xfer_len_o <= SPACE_W'(tdq_pkg::WORD_BYTES);
               end
            end
            tdq_pkg::link_refresh_state: if (bus_transfer_complete) begin
               state <= tdq_pkg::list_advance_state;
            end
            tdq_pkg::descriptor_fetch_state: if (bus_transfer_complete) begin
               state <= desc_own ? tdq_pkg::queue_wait_state : tdq_pkg::xmit_state_quiet;
            end
            tdq_pkg::queue_wait_state: begin
               if (remaining_byte_count == '0) begin
                  state <= desc_more ? tdq_pkg::status_writeback_state
                                     : tdq_pkg::list_advance_state;
                  if (desc_more) begin
                     // only the ownership half is written; size bits untouched
                     xfer_req_o <= 1'b1;
                     xfer_kind_o <= tdq_pkg::KIND_STATUS;
                     xfer_addr_o <= xmit_descriptor_pointer + tdq_pkg::CMDSTS_OFF;
                     xfer_len_o <= SPACE_W'(tdq_pkg::WORD_BYTES);
                     xfer_be_o <= tdq_pkg::UPPER_HALF_BE;
                     xfer_wdata_o <= cmdsts & ~(32'h0000_0001 << tdq_pkg::OWN_BIT);
                  end else begin
                     handle_valid_o <= 1'b1;
                     handle_data_o <= xmit_descriptor_pointer;
                  end
               end else if (queue_space_event) begin
                  state <= tdq_pkg::fragment_fetch_state;
                  xfer_req_o <= 1'b1;
                  xfer_kind_o <= tdq_pkg::KIND_FRAG;
                  xfer_addr_o <= fragment_pointer;
                  xfer_len_o <= burst_len;
                  xfer_be_o <= 4'hF;
               end
            end
            tdq_pkg::fragment_fetch_state: if (bus_transfer_complete) begin
               state <= tdq_pkg::queue_wait_state;
            end
            tdq_pkg::status_writeback_state: if (bus_transfer_complete) begin
               state <= tdq_pkg::list_advance_state;
            end
            tdq_pkg::list_advance_state: begin
               if (!link_null) begin
                  state <= tdq_pkg::descriptor_fetch_state;
                  xfer_req_o <= 1'b1;
                  xfer_kind_o <= tdq_pkg::KIND_DESC;
                  xfer_addr_o <= link;
                  xfer_len_o <= SPACE_W'(desc_len);
                  xfer_be_o <= 4'hF;
               end else begin
                  state <= tdq_pkg::xmit_state_quiet;
               end
            end
         endcase
      end
   end

   sequence s_null_advance;
      state == tdq_pkg::list_advance_state && link_null;
   endsequence
   sequence s_wrap_up;
      !xmit_enable_cmd && current_desc_done_flag && xmit_went_idle_status;
   endsequence
   property p_fetch_start;
      @(posedge core_clk_i) disable iff (rst_i)
      state == tdq_pkg::xmit_state_quiet && xmit_enable_cmd && !current_desc_done_flag
      |=> xfer_req_o && xfer_kind_o == tdq_pkg::KIND_DESC
          && xfer_addr_o == $past(xmit_descriptor_pointer);
   endproperty
   a_fetch_start: assert property (p_fetch_start) else $error("descriptor fetch missed");
   property p_refresh;
      @(posedge core_clk_i) disable iff (rst_i)
      state == tdq_pkg::xmit_state_quiet && xmit_enable_cmd && current_desc_done_flag
      |=> state == tdq_pkg::link_refresh_state && xfer_kind_o == tdq_pkg::KIND_REFRESH;
   endproperty
   a_refresh: assert property (p_refresh) else $error("link refresh missed");
   property p_not_owned;
      @(posedge core_clk_i) disable iff (rst_i)
      state == tdq_pkg::descriptor_fetch_state && xfer_done_i && !desc_own
      |=> state == tdq_pkg::xmit_state_quiet && xmit_went_idle_status;
   endproperty
   a_not_owned: assert property (p_not_owned) else $error("unowned descriptor not idled");
   property p_burst_len;
      @(posedge core_clk_i) disable iff (rst_i)
      state == tdq_pkg::queue_wait_state && remaining_byte_count != '0 && queue_space_event
      |=> xfer_req_o && xfer_len_o == $past(burst_len)
          && remaining_byte_count == $past(remaining_byte_count) - SIZE_W_L'($past(burst_len));
   endproperty
   a_burst_len: assert property (p_burst_len) else $error("fragment length wrong");
   property p_no_space;
      @(posedge core_clk_i) disable iff (rst_i)
      state == tdq_pkg::queue_wait_state && remaining_byte_count != '0
      && queue_free_space_i <= thr |=> !xfer_req_o && state == tdq_pkg::queue_wait_state;
   endproperty
   a_no_space: assert property (p_no_space) else $error("burst without space");
   property p_writeback;
      @(posedge core_clk_i) disable iff (rst_i)
      state == tdq_pkg::queue_wait_state && remaining_byte_count == '0 && desc_more
      |=> xfer_req_o && xfer_be_o == tdq_pkg::UPPER_HALF_BE
          && !xfer_wdata_o[tdq_pkg::OWN_BIT];
   endproperty
   a_writeback: assert property (p_writeback) else $error("status write wrong");
   property p_handle;
      @(posedge core_clk_i) disable iff (rst_i)
      state == tdq_pkg::queue_wait_state && remaining_byte_count == '0 && !desc_more
      |=> handle_valid_o && handle_data_o == $past(xmit_descriptor_pointer) ##1 !handle_valid_o;
   endproperty
   a_handle: assert property (p_handle) else $error("handle push wrong");
   property p_advance;
      @(posedge core_clk_i) disable iff (rst_i)
      state == tdq_pkg::list_advance_state && !link_null
      |=> xmit_descriptor_pointer == $past(link) && !current_desc_done_flag && xfer_req_o;
   endproperty
   a_advance: assert property (p_advance) else $error("advance to link wrong");
   property p_list_end;
      @(posedge core_clk_i) disable iff (rst_i)
      s_null_advance |=> s_wrap_up;
   endproperty
   a_list_end: assert property (p_list_end) else $error("list end handling wrong");
   property p_ptr_write;
      @(posedge core_clk_i) disable iff (rst_i)
      sw_wr && aw_addr == tdq_pkg::PTR_OFF && state != tdq_pkg::list_advance_state
      && !(state == tdq_pkg::status_writeback_state && xfer_done_i)
      |=> !current_desc_done_flag;
   endproperty
   a_ptr_write: assert property (p_ptr_write) else $error("done flag kept");
endmodule : tdq_sequencer
`default_nettype wire

/* tb/tdq_host_model.sv */
// host memory and bus-master engine stand-in
// assumes at most one request outstanding
`default_nettype none
module tdq_host_model (
   // request
   input wire logic clk_i,
   input wire logic req_i,
   input wire logic [1:0] kind_i,
   input wire logic [31:0] addr_i,
   input wire logic [11:0] len_i,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] be_i,
   // answer
   output logic rv_o = 1'b0,
   output logic [31:0] rd_o = 32'h0000_0000,
   output logic done_o = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] mem [int];
   logic [31:0] la [$];
   logic [17:0] lm [$];
   int nw;
   always begin
      @(posedge clk_i);
      if (req_i) begin
         la.push_back(addr_i);
         lm.push_back({kind_i, be_i, len_i});
         nw = (kind_i == 2'h0) ? int'(len_i) / 4 : int'(kind_i == 2'h1);
         if (kind_i == 2'h3) mem[addr_i][31:16] = wdata_i[31:16];
         // latency varies: prompt and slow answers
         repeat (la.size() % 3) @(posedge clk_i);
         for (int i = 0; i < nw; i++) begin
            rv_o <= 1'b1;
            rd_o <= mem[addr_i + 4 * i];
            @(posedge clk_i);
         end
         rv_o <= 1'b0;
         // released line must not keep the last word
         rd_o <= ~rd_o;
         done_o <= 1'b1;
         @(posedge clk_i);
         done_o <= 1'b0;
      end
   end
endmodule : tdq_host_model
`default_nettype wire

/* tb/tx_descriptor_dma_sequencer_bench.sv */
// bench for the transmit descriptor sequencer
// assumes the host model answers every request
`default_nettype none
module tx_descriptor_dma_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
   logic [3:0] awa = 0, ara = 0, xb;
   logic [11:0] fs = 12'h040, xl;
   logic [31:0] wd = 0, got, rd, xa, xw, rdd, hd;
   logic awr, wr, bv, arr, rv, rq, rdv, dn, hv;
   logic [1:0] br, rr, rsp, kd;
   int errors = 0, n_checks = 0;
   logic [31:0] hq [$];
   always #50 clk = ~clk;
   always @(posedge clk) if (hv) hq.push_back(hd);
   tdq_sequencer tdq_sequencer_inst (.core_clk_i(clk), .rst_i(rst), .s_awaddr_i(awa),
      .s_awvalid_i(awv), .s_awready_o(awr), .s_wdata_i(wd), .s_wstrb_i(4'hF),
      .s_wvalid_i(wv), .s_wready_o(wr), .s_bresp_o(br), .s_bvalid_o(bv), .s_bready_i(bry),
      .s_araddr_i(ara), .s_arvalid_i(arv), .s_arready_o(arr), .s_rdata_o(rd),
      .s_rresp_o(rr), .s_rvalid_o(rv), .s_rready_i(rry), .xfer_req_o(rq),
      .xfer_kind_o(kd), .xfer_addr_o(xa), .xfer_len_o(xl), .xfer_wdata_o(xw),
      .xfer_be_o(xb), .rd_valid_i(rdv), .rd_data_i(rdd), .xfer_done_i(dn),
      .queue_free_space_i(fs), .handle_valid_o(hv), .handle_data_o(hd));
   tdq_host_model tdq_host_model_inst (.clk_i(clk), .req_i(rq), .kind_i(kd), .addr_i(xa),
      .len_i(xl), .wdata_i(xw), .be_i(xb), .rv_o(rdv), .rd_o(rdd), .done_o(dn));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      do begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wr) wv <= 1'b0;
      end while ((awv && !awr) || (wv && !wr));
      do @(posedge clk); while (!bv);
      rsp = br;
      bry <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [3:0] a);
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      do @(posedge clk); while (!arr);
      arv <= 1'b0;
      do @(posedge clk); while (!rv);
      rry <= 1'b0;
      got = rd;
      rsp = rr;
   endtask : rreg
   // poll until the walker is back in its quiet state
   task automatic quiet;
      repeat (5) @(posedge clk);
      do rreg(4'hC); while (got[6:4] !== 3'h0);
   endtask : quiet
   // request log entry: kind, byte enables, length, address
   task automatic chkx(input int i, input logic [17:0] km, input logic [31:0] a);
      chk(32'(tdq_host_model_inst.lm[i]), 32'(km));
      chk(tdq_host_model_inst.la[i], a);
   endtask : chkx
   task automatic desc(input int a, input logic [31:0] l, input logic [31:0] c,
      input logic [31:0] p);
      tdq_host_model_inst.mem[a] = l;
      tdq_host_model_inst.mem[a + 4] = c;
      tdq_host_model_inst.mem[a + 8] = p;
   endtask : desc
   task automatic t_single;
      rreg(4'h4);
      chk(got, tdq_pkg::CFG_RESET);
      rreg(4'h2);
      chk(32'(rsp), 32'(tdq_pkg::RESP_DECERR));
      desc(256, 0, 32'h8000_0030, 32'h0000_0203);
      wreg(4'h8, 32'h0000_0100);
      chk(32'(rsp), 32'(tdq_pkg::RESP_OKAY));
      wreg(4'h6, 32'h0000_0001);
      chk(32'(rsp), 32'(tdq_pkg::RESP_DECERR));
      wreg(4'h0, 32'h0000_0001);
      repeat (20) @(posedge clk);
      chk(32'(tdq_host_model_inst.la.size()), 32'h1);
      fs <= 12'h050;
      quiet;
      chkx(0, {2'h0, 4'hF, 12'h00C}, 32'h0000_0100);
      chkx(1, {2'h2, 4'hF, 12'h030}, 32'h0000_0203);
      chk(hq.pop_front(), 32'h0000_0100);
      rreg(4'hC);
      chk(got, 32'h0000_0003);
      rreg(4'h0);
      chk(got, 32'h0000_0000);
      $display("single packet test done");
   endtask : t_single
   task automatic t_multi;
      desc(1024, 32'h0000_0500, 32'hC000_0060, 32'h0000_1001);
      desc(1280, 0, 32'h8000_0004, 32'h0000_2000);
      wreg(4'hC, 32'h0000_0001);
      wreg(4'h8, 32'h0000_0400);
      rreg(4'hC);
      chk(got, 32'h0000_0000);
      wreg(4'h0, 32'h0000_0001);
      quiet;
      chkx(3, {2'h2, 4'hF, 12'h050}, 32'h0000_1001);
      chkx(4, {2'h2, 4'hF, 12'h010}, 32'h0000_1051);
      chk(tdq_host_model_inst.la[5], 32'h0000_0404);
      chk(32'(tdq_host_model_inst.lm[5][15:12]), 32'h0000_000C);
      chk(tdq_host_model_inst.mem[1028], 32'h4000_0060);
      chkx(6, {2'h0, 4'hF, 12'h00C}, 32'h0000_0500);
      chkx(7, {2'h2, 4'hF, 12'h004}, 32'h0000_2000);
      chk(hq.pop_front(), 32'h0000_0500);
      chk(32'(tdq_host_model_inst.la.size()), 32'h8);
      $display("multi descriptor test done");
   endtask : t_multi
   task automatic t_refresh;
      tdq_host_model_inst.mem[1280] = 32'h0000_0600;
      desc(1536, 0, 32'h0000_0008, 0);
      wreg(4'hC, 32'h0000_0001);
      wreg(4'h0, 32'h0000_0001);
      // an unowned descriptor is fetched again while enabled; stop it
      do rreg(4'hC); while (got[0] !== 1'b1);
      wreg(4'h0, 32'h0000_0000);
      quiet;
      chk(32'(tdq_host_model_inst.lm[8][17:16]), 32'h1);
      chk(tdq_host_model_inst.la[8], 32'h0000_0500);
      chkx(9, {2'h0, 4'hF, 12'h00C}, 32'h0000_0600);
      rreg(4'hC);
      chk(got, 32'h0000_0001);
      wreg(4'h4, 32'h0002_0010);
      rreg(4'h4);
      chk(got, 32'h0002_0010);
      $display("refresh test done");
   endtask : t_refresh
   task automatic results;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : results
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_single;
      t_multi;
      t_refresh;
      results;
   end
   // whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      errors++;
      results;
   end
endmodule : tx_descriptor_dma_sequencer_bench
`default_nettype wire
